/* File: verilog/ucr_pkg.sv */
// Shared constants and types for the UART channel register front end
package ucr_pkg;

    // ==========================================================
    // Register offsets on the three-bit host address
    localparam logic [2:0] OFS_DATA      = 3'h0;
    localparam logic [2:0] OFS_IRQ_EN    = 3'h1;
    localparam logic [2:0] OFS_IDENT     = 3'h2;
    localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT = 3'h5;
    localparam logic [2:0] OFS_MODEM_STA = 3'h6;
    localparam logic [2:0] OFS_SCRATCH   = 3'h7;
    localparam logic [2:0] OFS_RESUME_1  = 3'h4;
    localparam logic [2:0] OFS_RESUME_2  = 3'h5;
    localparam logic [2:0] OFS_PAUSE_1   = 3'h6;
    localparam logic [2:0] OFS_PAUSE_2   = 3'h7;

    // ==========================================================
    // Field positions
    localparam int LINE_DIV_BIT  = 7;
    localparam int ENH_ON_BIT    = 4;
    localparam int FIFO_ON_BIT   = 0;
    localparam int EN_RX_DATA    = 0;
    localparam int EN_TX_EMPTY   = 1;
    localparam int EN_LINE_STAT  = 2;
    localparam int EN_MODEM      = 3;
    localparam int EN_SLEEP      = 4;
    localparam int EN_PAUSE      = 5;
    localparam int EN_RTS_RISE   = 6;
    localparam int EN_CTS_RISE   = 7;
    localparam int ALT_USED_BITS = 3;

    // ==========================================================
    // Codes, masks and reset values
    localparam logic [7:0] LINE_ENHANCED = 8'hBF;
    localparam logic [7:0] EN_BASE_MASK  = 8'h0F;
    localparam logic [7:0] EN_ENH_MASK   = 8'hE0;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_SCRATCH   = 8'hFF;
    localparam logic [7:0] RST_IDENT     = 8'h01;
    localparam logic [2:0] ID_LINE       = 3'h3;
    localparam logic [2:0] ID_RX_DATA    = 3'h2;
    localparam logic [2:0] ID_RX_TIMEOUT = 3'h6;
    localparam logic [2:0] ID_TX_EMPTY   = 3'h1;
    localparam logic [2:0] ID_NONE       = 3'h0;
    // Arbitrary neutral revision value
    localparam logic [7:0] REVISION_CODE = 8'h10;

    // ==========================================================
    // Queue depths of the two variants
    localparam int QUEUE_DEPTH_SMALL = 16;
    localparam int QUEUE_DEPTH_LARGE = 64;
    localparam int SHIFT_BITS        = 8;

    typedef enum logic [1:0] {
        BANK_NORMAL,
        BANK_DIVISOR,
        BANK_ENHANCED
    } ucr_bank_t;

endpackage : ucr_pkg

/* File: verilog/ucr_queue_if.sv */
// Byte queue handshake between the channel modules
`timescale 1ns/1ps
`default_nettype none
interface ucr_queue_if;
    logic       push;
    logic [7:0] pushData;
    logic       full;
    logic       pop;
    logic [7:0] popData;
    logic       empty;

    modport fill  (output push, output pushData, input full);
    modport drain (output pop, input popData, input empty);
    modport store (input push, input pushData, input pop,
                   output full, output popData, output empty);
endinterface : ucr_queue_if
`default_nettype wire

/* File: verilog/ucr_byte_queue.sv */
// Byte queue whose storage has no reset; reset clears only pointers and count
`timescale 1ns/1ps
`default_nettype none
module ucr_byte_queue #(
    parameter int DEPTH = ucr_pkg::QUEUE_DEPTH_SMALL
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Queue port
    ucr_queue_if.store q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } ucr_queue_state_t;

    ucr_queue_state_t state_r;
    ucr_queue_state_t state_nxt;
    logic [7:0]       mem [DEPTH];
    logic             doPush;
    logic             doPop;

    assign q.full    = state_r.count == FULL_COUNT;
    assign q.empty   = state_r.count == '0;
    assign q.popData = mem[state_r.rdPtr];
    assign doPush    = q.push && !q.full;
    assign doPop     = q.pop && !q.empty;

    always_comb
    begin
        state_nxt = state_r;
        if (doPush)
            state_nxt.wrPtr = state_r.wrPtr + 1'b1;
        if (doPop)
            state_nxt.rdPtr = state_r.rdPtr + 1'b1;
        state_nxt.count = state_r.count + (AW + 1)'(doPush)
                        - (AW + 1)'(doPop);
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    // Storage has no reset so held bytes stay put
    always_ff @(posedge sys_clk)
    begin
        if (doPush)
            mem[state_r.wrPtr] <= q.pushData;
    end
endmodule : ucr_byte_queue
`default_nettype wire

/* File: verilog/ucr_rx_shifter.sv */
// Serial-to-parallel receive stage feeding the receive queue
`timescale 1ns/1ps
`default_nettype none
module ucr_rx_shifter (
    // Clock and reset
    input wire logic   sys_clk,
    input wire logic   reset_n,
    // Serial bits, least significant first
    input wire logic   serBit,
    input wire logic   serStb,
    // Queue side
    ucr_queue_if.fill  q
);
    typedef struct packed {
        logic [2:0] count;
        logic [7:0] shift;
        logic       pending;
        logic [7:0] byteOut;
    } ucr_shift_state_t;

    ucr_shift_state_t state_r;
    ucr_shift_state_t state_nxt;

    assign q.push     = state_r.pending;
    assign q.pushData = state_r.byteOut;

    always_comb
    begin
        state_nxt         = state_r;
        state_nxt.pending = 1'b0;
        if (serStb)
        begin
            state_nxt.shift = {serBit, state_r.shift[7:1]};
            state_nxt.count = state_r.count + 3'h1;
            if (state_r.count == 3'(ucr_pkg::SHIFT_BITS - 1))
            begin
                state_nxt.pending = 1'b1;
                state_nxt.byteOut = {serBit, state_r.shift[7:1]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end
endmodule : ucr_rx_shifter
`default_nettype wire

/* File: verilog/ucr_channel.sv */
// One UART channel: host register access and interrupt masking
//
// Behaviour
// - Receive path is an 8-bit shifter feeding a 16 or 64 byte queue.
// - Data offset writes enter transmit queue; reads there return receive data.
// - Reset keeps receive and transmit data bytes; only control state clears.
// - Seven separately controllable interrupt enable bits in the channel; enable bit 4 is the sleep enable.
// - Any single enabled source can drive the interrupt output alone.
// - Writing 1 to an enable bit unmasks its source; 0 masks it.
// - Masked sources show neither as pending nor on the interrupt output.
// - Line and modem status keep updating whatever the mask.
// - Enable bits 4 to 7 act only while enhanced bit 4 is set.
// - Enable bit 0 gates both data-available and time-out interrupts.
// - Identification value holds steady while the host reads it.
`timescale 1ns/1ps
`default_nettype none
module ucr_channel #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // Clock and master reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Host register port
    input  wire logic [2:0]  hostAddr,
    input  wire logic [7:0]  hostWrData,
    input  wire logic        hostWr,
    input  wire logic        hostRd,
    output logic      [7:0]  hostRdData,
    // Serial receive bits
    input  wire logic        rxSerBit,
    input  wire logic        rxSerStb,
    // Transmit byte stream
    output logic      [7:0]  txByte,
    output logic             txValid,
    input  wire logic        txTake,
    // Status and event inputs
    input  wire logic [7:0]  lineStatusIn,
    input  wire logic [7:0]  modemStatusIn,
    input  wire logic        lineStatusEvt,
    input  wire logic        modemStatusEvt,
    input  wire logic        rxTimeoutEvt,
    input  wire logic        pauseCharEvt,
    input  wire logic        rtsRiseEvt,
    input  wire logic        ctsRiseEvt,
    // Interrupt and configuration outputs
    output logic             interruptOutput,
    output logic             sleepMode,
    output logic      [15:0] divisorOut,
    output logic      [7:0]  lineControl,
    output logic      [7:0]  modemControl,
    output logic      [7:0]  alternateFunction,
    output logic      [7:0]  enhancedFeatures,
    output logic      [15:0] resumeChars,
    output logic      [15:0] pauseChars
);
    localparam int DEPTH = LARGE_VARIANT ? ucr_pkg::QUEUE_DEPTH_LARGE
                                         : ucr_pkg::QUEUE_DEPTH_SMALL;

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] lineCtl;
        logic [7:0] modemCtl;
        logic [7:0] scratch;
        logic [7:0] irqEnable;
        logic [7:0] enhanced;
        logic [7:0] altFunc;
        logic       fifosOn;
        logic [7:0] divLow;
        logic [7:0] divHigh;
        logic [7:0] resume1;
        logic [7:0] resume2;
        logic [7:0] pause1;
        logic [7:0] pause2;
        logic [7:0] identHold;
        logic [7:0] rdData;
        logic       irq;
        logic       sleep;
        logic       txValid;
    } ucr_ctrl_t;

    typedef struct packed {
        logic [7:0] rxHold;
        logic [7:0] txHold;
        logic [7:0] txOut;
    } ucr_data_t;

    ucr_ctrl_t ctrl_r;
    ucr_ctrl_t ctrl_nxt;
    ucr_data_t data_r;
    ucr_data_t data_nxt;

    ucr_queue_if rxQ ();
    ucr_queue_if txQ ();

    // ==========================================================
    // Register bank decode from line control
    function automatic ucr_pkg::ucr_bank_t bankOf(input logic [7:0] line_control);
        if (line_control == ucr_pkg::LINE_ENHANCED)
            bankOf = ucr_pkg::BANK_ENHANCED;
        else if (line_control[ucr_pkg::LINE_DIV_BIT])
            bankOf = ucr_pkg::BANK_DIVISOR;
        else
            bankOf = ucr_pkg::BANK_NORMAL;
    endfunction : bankOf

    // ==========================================================
    // Queues and receive shifter
    ucr_rx_shifter u_rx_shifter (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .serBit  (rxSerBit),
        .serStb  (rxSerStb),
        .q       (rxQ.fill)
    );

    ucr_byte_queue #(.DEPTH(DEPTH)) u_rx_queue (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .q       (rxQ.store)
    );

    ucr_byte_queue #(.DEPTH(DEPTH)) u_tx_queue (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .q       (txQ.store)
    );

    // ==========================================================
    // Interrupt sources and masking
    ucr_pkg::ucr_bank_t bank;
    logic [7:0]         irqSrc;
    logic [7:0]         effMask;
    logic [7:0]         pending;
    logic [2:0]         identCode;
    logic [7:0]         identNow;
    logic               dataWr;
    logic               dataRd;
    logic               identRd;
    logic               txLoad;

    assign bank = bankOf(ctrl_r.lineCtl);

    always_comb
    begin
        irqSrc                        = '0;
        irqSrc[ucr_pkg::EN_RX_DATA]   = !rxQ.empty || rxTimeoutEvt;
        irqSrc[ucr_pkg::EN_TX_EMPTY]  = txQ.empty && !ctrl_r.txValid;
        irqSrc[ucr_pkg::EN_LINE_STAT] = lineStatusEvt;
        irqSrc[ucr_pkg::EN_MODEM]     = modemStatusEvt;
        irqSrc[ucr_pkg::EN_PAUSE]     = pauseCharEvt;
        irqSrc[ucr_pkg::EN_RTS_RISE]  = rtsRiseEvt;
        irqSrc[ucr_pkg::EN_CTS_RISE]  = ctsRiseEvt;
        effMask = ucr_pkg::EN_BASE_MASK;
        if (ctrl_r.enhanced[ucr_pkg::ENH_ON_BIT])
            effMask = effMask | ucr_pkg::EN_ENH_MASK;
        pending = irqSrc & ctrl_r.irqEnable & effMask;
    end

    always_comb
    begin
        identCode = ucr_pkg::ID_NONE;
        if (pending[ucr_pkg::EN_LINE_STAT])
            identCode = ucr_pkg::ID_LINE;
        else if (pending[ucr_pkg::EN_RX_DATA])
            identCode = rxQ.empty ? ucr_pkg::ID_RX_TIMEOUT
                                  : ucr_pkg::ID_RX_DATA;
        else if (pending[ucr_pkg::EN_TX_EMPTY])
            identCode = ucr_pkg::ID_TX_EMPTY;
        identNow = {{2{ctrl_r.fifosOn}},
                    pending[ucr_pkg::EN_RTS_RISE]
                        || pending[ucr_pkg::EN_CTS_RISE],
                    pending[ucr_pkg::EN_PAUSE],
                    identCode,
                    ~|pending};
    end

    // ==========================================================
    // Host access decode
    assign dataWr  = hostWr && hostAddr == ucr_pkg::OFS_DATA
                  && bank == ucr_pkg::BANK_NORMAL;
    assign dataRd  = hostRd && hostAddr == ucr_pkg::OFS_DATA
                  && bank == ucr_pkg::BANK_NORMAL;
    assign identRd = hostRd && hostAddr == ucr_pkg::OFS_IDENT
                  && bank == ucr_pkg::BANK_NORMAL;
    assign txLoad  = !ctrl_r.txValid || txTake;

    assign txQ.push     = dataWr;
    assign txQ.pushData = hostWrData;
    assign txQ.pop      = txLoad && !txQ.empty;
    assign rxQ.pop      = dataRd && !rxQ.empty;

    // ==========================================================
    // Next state
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        data_nxt = data_r;

        if (!identRd)
            ctrl_nxt.identHold = identNow;

        if (hostWr)
        begin
            unique case (bank)
                ucr_pkg::BANK_DIVISOR:
                    if (hostAddr == ucr_pkg::OFS_DATA)
                        ctrl_nxt.divLow = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_IRQ_EN)
                        ctrl_nxt.divHigh = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_IDENT)
                        ctrl_nxt.altFunc = {5'h0,
                            hostWrData[ucr_pkg::ALT_USED_BITS-1:0]};
                ucr_pkg::BANK_ENHANCED:
                    if (hostAddr == ucr_pkg::OFS_IDENT)
                        ctrl_nxt.enhanced = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_RESUME_1)
                        ctrl_nxt.resume1 = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_RESUME_2)
                        ctrl_nxt.resume2 = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_PAUSE_1)
                        ctrl_nxt.pause1 = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_PAUSE_2)
                        ctrl_nxt.pause2 = hostWrData;
                ucr_pkg::BANK_NORMAL:
                    if (hostAddr == ucr_pkg::OFS_DATA)
                        data_nxt.txHold = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_IRQ_EN)
                        ctrl_nxt.irqEnable = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_IDENT)
                        ctrl_nxt.fifosOn = hostWrData[ucr_pkg::FIFO_ON_BIT];
                    else if (hostAddr == ucr_pkg::OFS_MODEM_CTL)
                        ctrl_nxt.modemCtl = hostWrData;
                    else if (hostAddr == ucr_pkg::OFS_SCRATCH)
                        ctrl_nxt.scratch = hostWrData;
                default: ;
            endcase
            if (hostAddr == ucr_pkg::OFS_LINE_CTL)
                ctrl_nxt.lineCtl = hostWrData;
        end

        if (rxQ.pop)
            data_nxt.rxHold = rxQ.popData;

        if (hostRd)
        begin
            ctrl_nxt.rdData = '0;
            if (hostAddr == ucr_pkg::OFS_LINE_CTL)
                ctrl_nxt.rdData = ctrl_r.lineCtl;
            else
            begin
                unique case (bank)
                    ucr_pkg::BANK_DIVISOR:
                        if (hostAddr == ucr_pkg::OFS_DATA)
                            ctrl_nxt.rdData =
                                ({ctrl_r.divHigh, ctrl_r.divLow} == '0)
                                ? ucr_pkg::REVISION_CODE : ctrl_r.divLow;
                        else if (hostAddr == ucr_pkg::OFS_IRQ_EN)
                            ctrl_nxt.rdData = ctrl_r.divHigh;
                        else if (hostAddr == ucr_pkg::OFS_IDENT)
                            ctrl_nxt.rdData = ctrl_r.altFunc;
                    ucr_pkg::BANK_ENHANCED:
                        if (hostAddr == ucr_pkg::OFS_IDENT)
                            ctrl_nxt.rdData = ctrl_r.enhanced;
                        else if (hostAddr == ucr_pkg::OFS_RESUME_1)
                            ctrl_nxt.rdData = ctrl_r.resume1;
                        else if (hostAddr == ucr_pkg::OFS_RESUME_2)
                            ctrl_nxt.rdData = ctrl_r.resume2;
                        else if (hostAddr == ucr_pkg::OFS_PAUSE_1)
                            ctrl_nxt.rdData = ctrl_r.pause1;
                        else if (hostAddr == ucr_pkg::OFS_PAUSE_2)
                            ctrl_nxt.rdData = ctrl_r.pause2;
                    ucr_pkg::BANK_NORMAL:
                        unique case (hostAddr)
                            ucr_pkg::OFS_DATA:
                                ctrl_nxt.rdData = rxQ.empty ? data_r.rxHold
                                                : rxQ.popData;
                            ucr_pkg::OFS_IRQ_EN:
                                ctrl_nxt.rdData = ctrl_r.irqEnable;
                            ucr_pkg::OFS_IDENT:
                                ctrl_nxt.rdData = ctrl_r.identHold;
                            ucr_pkg::OFS_MODEM_CTL:
                                ctrl_nxt.rdData = ctrl_r.modemCtl;
                            ucr_pkg::OFS_LINE_STAT:
                                ctrl_nxt.rdData = lineStatusIn;
                            ucr_pkg::OFS_MODEM_STA:
                                ctrl_nxt.rdData = modemStatusIn;
                            ucr_pkg::OFS_SCRATCH:
                                ctrl_nxt.rdData = ctrl_r.scratch;
                            default: ;
                        endcase
                    default: ;
                endcase
            end
        end

        if (txLoad)
        begin
            ctrl_nxt.txValid = !txQ.empty;
            if (!txQ.empty)
                data_nxt.txOut = txQ.popData;
        end

        ctrl_nxt.irq   = |pending;
        ctrl_nxt.sleep = ctrl_r.irqEnable[ucr_pkg::EN_SLEEP]
                      && ctrl_r.enhanced[ucr_pkg::ENH_ON_BIT];
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r           <= '0;
            ctrl_r.scratch   <= ucr_pkg::RST_SCRATCH;
            ctrl_r.identHold <= ucr_pkg::RST_IDENT;
        end
        else
            ctrl_r <= ctrl_nxt;
    end

    // Data bytes have no reset
    always_ff @(posedge sys_clk)
    begin
        data_r <= data_nxt;
    end

    // ==========================================================
    // Outputs
    assign hostRdData        = ctrl_r.rdData;
    assign txByte            = data_r.txOut;
    assign txValid           = ctrl_r.txValid;
    assign interruptOutput   = ctrl_r.irq;
    assign sleepMode         = ctrl_r.sleep;
    assign divisorOut        = {ctrl_r.divHigh, ctrl_r.divLow};
    assign lineControl       = ctrl_r.lineCtl;
    assign modemControl      = ctrl_r.modemCtl;
    assign alternateFunction = ctrl_r.altFunc;
    assign enhancedFeatures  = ctrl_r.enhanced;
    assign resumeChars       = {ctrl_r.resume2, ctrl_r.resume1};
    assign pauseChars        = {ctrl_r.pause2, ctrl_r.pause1};
endmodule : ucr_channel
`default_nettype wire

/* File: dv/ucr_monitor.sv */
// Assertion checker for the channel register front end
`timescale 1ns/1ps
`default_nettype none
module ucr_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // Host port
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic       hostWr,
    input wire logic       hostRd,
    input wire logic [7:0] hostRdData,
    // Transmit stream
    input wire logic [7:0] txByte,
    input wire logic       txValid,
    // Status and sources
    input wire logic [7:0] lineStatusIn,
    input wire logic [7:0] modemStatusIn,
    input wire logic       lineStatusEvt,
    input wire logic       modemStatusEvt,
    input wire logic       pauseCharEvt,
    input wire logic       rtsRiseEvt,
    input wire logic       ctsRiseEvt,
    // Outputs
    input wire logic       interruptOutput,
    input wire logic       sleepMode,
    input wire logic [7:0] lineControl,
    input wire logic [7:0] enhancedFeatures
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Shadow of the enable register
    logic [7:0] enR;
    logic       nrm;
    assign nrm = !lineControl[7];
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            enR <= 8'h00;
        else if (hostWr && nrm && hostAddr == 3'h1)
            enR <= hostWrData;
    // ==========================================================
    // Transmit write into an idle path
    sequence txWr;
        hostWr && nrm && hostAddr == 3'h0 && !txValid ##1 !txValid;
    endsequence
    a_base_src_on: assert property (
        |(enR[3:2] & {modemStatusEvt, lineStatusEvt}) |=> interruptOutput)
        else $error("enabled source gave no interrupt");
    a_all_masked: assert property (
        enR == 8'h00 |=> !interruptOutput)
        else $error("interrupt with all sources masked");
    a_enh_gated: assert property (
        enR[3:0] == 4'h0 && !enhancedFeatures[4] |=> !interruptOutput)
        else $error("upper enable acted without enhanced bit");
    a_enh_src_on: assert property (
        enhancedFeatures[4] && |(enR[7:5] &
        {ctsRiseEvt, rtsRiseEvt, pauseCharEvt}) |=> interruptOutput)
        else $error("enhanced source gave no interrupt");
    a_sleep_mode: assert property (
        1'b1 |=> sleepMode == $past(enR[4] && enhancedFeatures[4]))
        else $error("sleep output wrong");
    a_line_read: assert property (
        hostRd && nrm && hostAddr == 3'h5 |=> hostRdData == $past(lineStatusIn))
        else $error("line status read wrong");
    a_modem_read: assert property (
        hostRd && nrm && hostAddr == 3'h6 |=> hostRdData == $past(modemStatusIn))
        else $error("modem status read wrong");
    a_tx_byte_out: assert property (
        txWr |=> txValid && txByte == $past(hostWrData, 2))
        else $error("transmit byte not presented");
endmodule : ucr_monitor
`default_nettype wire

/* File: dv/ucr_host_model.sv */
// Host processor model for the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module ucr_host_model (
    // Clock
    input wire logic   sys_clk,
    // Register port
    output logic [2:0] hostAddr,
    output logic [7:0] hostWrData,
    output logic       hostWr,
    output logic       hostRd
);
    initial
    begin
        hostAddr = 3'h0;
        hostWrData = 8'h00;
        hostWr = 1'b0;
        hostRd = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        hostAddr <= a;
        hostWrData <= d;
        hostWr <= 1'b1;
        @(posedge sys_clk);
        hostWr <= 1'b0;
        hostWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        hostAddr <= a;
        hostRd <= 1'b1;
        @(posedge sys_clk);
        hostRd <= 1'b0;
    endtask : rd
endmodule : ucr_host_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the channel register front end
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [2:0]  hostAddr;
    logic [7:0]  hostWrData, hostRdData, txByte, b, t, mc;
    logic [7:0]  lsi = 8'h00, msi = 8'h00;
    logic        hostWr, hostRd, txValid, irqOut, sleep, rdPend = 1'b0;
    logic        rxSerBit = 1'b0, rxSerStb = 1'b0, txTake = 1'b0;
    logic [5:0]  evt = 6'h00;
    logic [15:0] divisorOut, resumeChars, pauseChars;
    logic [7:0]  masks [7] = '{8'h04, 8'h08, 8'h01, 8'h20, 8'h40, 8'h80, 8'h02};
    logic [31:0] seed = 32'd69;
    logic [7:0]  expq [$];
    int          n_mismatch = 0, checks_done = 0;
    always #10 sys_clk = ~sys_clk;
    ucr_host_model host (.sys_clk(sys_clk), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd));
    ucr_channel dut (.sys_clk(sys_clk), .reset_n(reset_n), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd),
        .hostRdData(hostRdData), .rxSerBit(rxSerBit), .rxSerStb(rxSerStb),
        .txByte(txByte), .txValid(txValid), .txTake(txTake),
        .lineStatusIn(lsi), .modemStatusIn(msi), .lineStatusEvt(evt[0]),
        .modemStatusEvt(evt[1]), .rxTimeoutEvt(evt[2]), .pauseCharEvt(evt[3]),
        .rtsRiseEvt(evt[4]), .ctsRiseEvt(evt[5]), .interruptOutput(irqOut),
        .sleepMode(sleep), .divisorOut(divisorOut), .lineControl(),
        .modemControl(mc), .alternateFunction(), .enhancedFeatures(),
        .resumeChars(resumeChars), .pauseChars(pauseChars));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic rdx(input logic [2:0] a, input logic [7:0] e);
        expq.push_back(e);
        host.rd(a);
    endtask : rdx
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // ==========================================================
    // Read results against the oldest expectation
    always @(posedge sys_clk)
    begin
        if (rdPend)
            chk("read", hostRdData, expq.pop_front());
        rdPend <= hostRd;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        lsi <= rnd();
        msi <= rnd();
        rdx(3'h1, 8'h00);
        rdx(3'h2, 8'h01);
        rdx(3'h7, 8'hFF);
        for (int e = 0; e < 2; e++)
        begin
            for (int j = 0; j < 7; j++)
            begin
                @(posedge sys_clk);
                evt <= 6'h01 << j;
                wt(2);
                chk("masked", irqOut, 1'b0);
                host.wr(3'h1, masks[j]);
                wt(2);
                chk("enabled", irqOut, j < 3 || j == 6 || e == 1);
                host.wr(3'h1, 8'h00);
            end
            host.wr(3'h3, 8'hBF);
            host.wr(3'h2, 8'h10);
            host.wr(3'h3, 8'h00);
        end
        host.wr(3'h1, 8'h10);
        wt(2);
        chk("sleep", sleep, 1'b1);
        host.wr(3'h1, 8'h00);
        @(posedge sys_clk);
        evt <= 6'h3F;
        rdx(3'h5, lsi);
        rdx(3'h6, msi);
        t = rnd();
        host.wr(3'h0, t);
        wt(2);
        chk("txValid", txValid, 1'b1);
        chk("txByte", txByte, t);
        @(posedge sys_clk);
        txTake <= 1'b1;
        @(posedge sys_clk);
        txTake <= 1'b0;
        b = rnd();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            rxSerStb <= 1'b1;
            rxSerBit <= b[i];
        end
        @(posedge sys_clk);
        rxSerStb <= 1'b0;
        wt(3);
        rdx(3'h0, b);
        host.wr(3'h1, 8'h0F);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        wt(2);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rdx(3'h1, 8'h00);
        rdx(3'h0, b);
        chk("txHeld", txByte, t);
        host.wr(3'h4, t);
        host.wr(3'h3, 8'h80);
        rdx(3'h0, ucr_pkg::REVISION_CODE);
        host.wr(3'h0, 8'h34);
        host.wr(3'h1, 8'h12);
        host.wr(3'h2, 8'hFF);
        rdx(3'h2, 8'h07);
        chk("divisor", divisorOut, 16'h1234);
        host.wr(3'h3, 8'hBF);
        for (int i = 4; i < 8; i++)
            host.wr(i[2:0], 8'(8'hA0 + i));
        host.wr(3'h3, 8'h00);
        chk("resume", resumeChars, 16'hA5A4);
        chk("pause", pauseChars, 16'hA7A6);
        chk("modemCtl", mc, t);
        close_out();
    end
endmodule : tb
bind ucr_channel ucr_monitor mon (.*);
`default_nettype wire
